/* rtl/direct_move_defines.svh */
`ifndef DIRECT_MOVE_DEFINES_SVH
`define DIRECT_MOVE_DEFINES_SVH

// ============================================================================
// Operation codes
`define OP_LOAD13_W     8'h08
`define OP_LOAD13_H     8'h09
`define OP_LOAD13_B     8'h0a
`define OP_STORE13_W    8'h18
`define OP_STORE13_H    8'h19
`define OP_STORE13_B    8'h1a
`define OP_TOPTR_W      8'h0c
`define OP_TOPTR_H      8'h0d
`define OP_TOPTR_B      8'h0e
`define OP_FROMPTR_W    8'h1c
`define OP_FROMPTR_H    8'h1d
`define OP_FROMPTR_B    8'h1e
`define OP_PUSH_W       8'h0b
`define OP_POP_W        8'h1b
`define OP_RES_LOAD     8'hbc
`define OP_RES_STORE    8'hbd
`define OP_EXT_E        8'h9f
`define EXT_COPROC_TOP  2'h3

// ============================================================================
// Register numbers, pointer steps and memory accesses per move
`define GR_THIRTEEN     4'hd
`define GR_STACK        4'hf
`define STEP_WORD       32'h0000_0004
`define STEP_HALF       32'h0000_0002
`define STEP_BYTE       32'h0000_0001
`define MOVE_MEM_CYCLES 2'h2

`endif

/* rtl/direct_move_pkg.sv */
package direct_move_pkg;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RD   = 3'b001,
        S_RES  = 3'b010,
        S_WR   = 3'b011,
        S_WB   = 3'b100
    } exec_state_type;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } access_size_type;

endpackage : direct_move_pkg

/* rtl/direct_address_move_exec.sv */
`timescale 1ns/1ps
`include "direct_move_defines.svh"

module direct_address_move_exec
    import direct_move_pkg::*;
(
    input  wire logic        clk,            // Core clock.
    input  wire logic        srst,           // Synchronous reset, active high.
    input  wire logic        instr_valid,    // Instruction offered.
    output logic             instr_ready,    // Executor idle and taking instructions.
    input  wire logic [15:0] instr,          // Instruction half-word.
    input  wire logic [31:0] r13_in,         // Value of general_register_thirteen.
    input  wire logic [31:0] r15_in,         // Value of stack_pointer_register.
    input  wire logic [31:0] ri_in,          // Value of the register named in instr[3:0].
    output logic             mem_req,        // Data memory request, held until ack.
    output logic             mem_we,         // Request is a write.
    output logic [31:0]      mem_addr,       // Byte address.
    output logic [1:0]       mem_size,       // Access size code.
    output logic [31:0]      mem_wdata,      // Write data, right aligned.
    input  wire logic        mem_ack,        // Memory finished the access.
    input  wire logic [31:0] mem_rdata,      // Read data, right aligned.
    output logic             res_wr,         // Pulse: word to resource channel.
    output logic             res_rd,         // Pulse: word taken from resource channel.
    output logic [3:0]       res_chan,       // Resource channel number.
    output logic [31:0]      res_wdata,      // Word to the channel.
    input  wire logic [31:0] res_rdata,      // Word from the channel, valid with res_rd.
    output logic             gr_we,          // Pulse: general register write.
    output logic [3:0]       gr_idx,         // Register written.
    output logic [31:0]      gr_wdata,       // Value written.
    output logic             flags_we,       // Condition flag write, never raised.
    output logic             coproc_reject,  // Pulse: coprocessor instruction refused.
    output logic             done            // Pulse: instruction finished.
);

    // ========================================================================
    // Decode
    wire logic [7:0]  op        = instr[15:8];
    wire logic [3:0]  lo        = op[3:0];
    wire logic        to_dir    = op[4];
    wire logic        is_dir    = (op[7:5] == 3'h0) && lo[3] && (lo != 4'hf);
    wire logic        is_reg13  = is_dir && (lo[3:2] == 2'b10) && (lo != 4'hb);
    wire logic        is_ptr13  = is_dir && (lo[3:2] == 2'b11);
    wire logic        is_stack  = is_dir && (lo == 4'hb);
    wire logic        is_resld  = (op == `OP_RES_LOAD);
    wire logic        is_resst  = (op == `OP_RES_STORE);
    wire logic        is_coproc = (op == `OP_EXT_E) && (instr[7:6] == `EXT_COPROC_TOP);
    wire logic        take      = instr_valid && instr_ready;
    wire access_size_type sz    = (lo[1:0] == 2'b01) ? SZ_HALF :
                                  (lo[1:0] == 2'b10) ? SZ_BYTE : SZ_WORD;
    wire logic [31:0] step      = (sz == SZ_HALF) ? `STEP_HALF :
                                  (sz == SZ_BYTE) ? `STEP_BYTE : `STEP_WORD;
    wire logic [31:0] dir_addr  = (sz == SZ_WORD) ? {22'h0, instr[7:0], 2'b00} :
                                  (sz == SZ_HALF) ? {23'h0, instr[7:0], 1'b0} :
                                                    {24'h0, instr[7:0]};
    wire logic [31:0] stk_down  = r15_in - `STEP_WORD;
    wire logic [31:0] ri_up     = ri_in + `STEP_WORD;

    // Source, destination and write-back chosen per instruction form.
    wire logic [31:0] src_sel = is_reg13 ? dir_addr :
                                is_ptr13 ? (to_dir ? r13_in : dir_addr) :
                                is_stack ? (to_dir ? r15_in : dir_addr) : ri_in;
    wire logic [31:0] dst_sel = is_reg13 ? dir_addr :
                                is_ptr13 ? (to_dir ? dir_addr : r13_in) :
                                is_stack ? (to_dir ? dir_addr : stk_down) : ri_in;
    wire logic [31:0] wb_sel  = is_ptr13 ? r13_in + step :
                                is_stack ? (to_dir ? r15_in + `STEP_WORD : stk_down) : ri_up;
    wire logic [3:0]  wb_reg  = (is_reg13 || is_ptr13) ? `GR_THIRTEEN :
                                is_stack ? `GR_STACK : instr[3:0];
    wire logic        exec_op = is_dir || is_resld || is_resst;
    // Every direct move except a register-13 store reads memory first.
    wire logic        need_rd = (is_dir && !(is_reg13 && to_dir)) || is_resld;

    function automatic logic [31:0] fit(input access_size_type s, input logic [31:0] d);
        fit = (s == SZ_BYTE) ? {24'h0, d[7:0]} : (s == SZ_HALF) ? {16'h0, d[15:0]} : d;
    endfunction : fit

    // ========================================================================
    // Execution state
    exec_state_type  state_ff, nxt_state;
    logic [15:0]     ir_ff;
    logic [31:0]     src_ff, dst_ff, wb_val_ff, data_ff, nxt_data;
    logic [3:0]      wb_idx_ff;
    logic [1:0]      size_ff;
    logic            do_res_ff, do_wr_ff, wb_data_ff, wb_en_ff, reject_ff;
    logic [1:0]      acc_cnt_ff;

    wire logic [7:0] ir_op = ir_ff[15:8];

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (take && exec_op) begin
                    nxt_state = need_rd ? S_RD : is_resst ? S_RES : S_WR;
                end
            end
            S_RD: begin
                if (mem_ack) begin
                    nxt_state = do_res_ff ? S_RES : (do_wr_ff ? S_WR : S_WB);
                end
            end
            S_RES: begin
                nxt_state = do_wr_ff ? S_WR : S_WB;
            end
            S_WR: begin
                if (mem_ack) begin
                    nxt_state = S_WB;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    assign nxt_data = (state_ff == S_IDLE) ? fit(sz, r13_in) :
                      (state_ff == S_RD && mem_ack) ? fit(access_size_type'(size_ff), mem_rdata) :
                      (state_ff == S_RES && !do_wr_ff) ? data_ff :
                      (state_ff == S_RES) ? res_rdata : data_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff   <= S_IDLE;
            acc_cnt_ff <= 2'h0;
            reject_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            reject_ff  <= take && is_coproc;
            if (take) begin
                acc_cnt_ff <= 2'h0;
            end else if (mem_req && mem_ack) begin
                acc_cnt_ff <= acc_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ir_ff      <= 16'h0;
            src_ff     <= 32'h0;
            dst_ff     <= 32'h0;
            wb_val_ff  <= 32'h0;
            data_ff    <= 32'h0;
            wb_idx_ff  <= 4'h0;
            size_ff    <= SZ_WORD;
            do_res_ff  <= 1'b0;
            do_wr_ff   <= 1'b0;
            wb_data_ff <= 1'b0;
            wb_en_ff   <= 1'b0;
        end else begin
            data_ff <= nxt_data;
            if (take) begin
                ir_ff      <= instr;
                src_ff     <= src_sel;
                dst_ff     <= dst_sel;
                wb_val_ff  <= wb_sel;
                wb_idx_ff  <= wb_reg;
                size_ff    <= (is_resld || is_resst) ? SZ_WORD : sz;
                do_res_ff  <= is_resld || is_resst;
                do_wr_ff   <= (is_dir && (to_dir || !is_reg13)) || is_resst;
                wb_data_ff <= is_reg13 && !to_dir;
                wb_en_ff   <= !(is_reg13 && to_dir);
            end
        end
    end

    // ========================================================================
    // Outputs
    assign instr_ready   = (state_ff == S_IDLE);
    assign mem_req       = (state_ff == S_RD) || (state_ff == S_WR);
    assign mem_we        = (state_ff == S_WR);
    assign mem_addr      = (state_ff == S_WR) ? dst_ff : src_ff;
    assign mem_size      = size_ff;
    assign mem_wdata     = data_ff;
    assign res_wr        = (state_ff == S_RES) && !do_wr_ff;
    assign res_rd        = (state_ff == S_RES) && do_wr_ff;
    assign res_chan      = ir_ff[7:4];
    assign res_wdata     = data_ff;
    assign gr_we         = (state_ff == S_WB) && wb_en_ff;
    assign gr_idx        = wb_idx_ff;
    assign gr_wdata      = wb_data_ff ? data_ff : wb_val_ff;
    // The pointer is written back on the last cycle, so a following instruction that reads it
    // needs the no-operation slot that software leaves.
    assign flags_we      = 1'b0;
    assign coproc_reject = reject_ff;
    assign done          = (state_ff == S_WB);

    // ========================================================================
    // Checks
    sequence s_wb_of(logic [7:0] code);
        state_ff == S_WB && ir_op == code;
    endsequence

    word_scale_a: assert property (@(posedge clk) disable iff (srst)
        mem_req && ir_op == `OP_LOAD13_W |-> mem_addr == {22'h0, ir_ff[7:0], 2'b00})
        else $error("word direct address not scaled by four");
    zero_ext_a: assert property (@(posedge clk) disable iff (srst)
        mem_req && (ir_op == `OP_LOAD13_B || ir_op == `OP_STORE13_W) |-> mem_addr[31:10] == 22'h0)
        else $error("direct address not zero extended");
    load13_a: assert property (@(posedge clk) disable iff (srst)
        s_wb_of(`OP_LOAD13_W) |-> gr_we && gr_idx == `GR_THIRTEEN && gr_wdata == $past(mem_rdata))
        else $error("direct load did not reach register thirteen");
    store13_a: assert property (@(posedge clk) disable iff (srst)
        s_wb_of(`OP_STORE13_W) |-> !gr_we && $past(mem_we) && acc_cnt_ff == 2'h1)
        else $error("direct store wrong");
    two_cycles_a: assert property (@(posedge clk) disable iff (srst)
        s_wb_of(`OP_TOPTR_W) or s_wb_of(`OP_FROMPTR_W) or s_wb_of(`OP_POP_W)
        |-> acc_cnt_ff == `MOVE_MEM_CYCLES && gr_we)
        else $error("memory to memory move not two cycles");
    push_a: assert property (@(posedge clk) disable iff (srst)
        state_ff == S_WR && ir_op == `OP_PUSH_W |-> ##[1:1000] (gr_we && gr_wdata == dst_ff
        && gr_idx == `GR_STACK))
        else $error("stack top not new stack pointer");
    half_step_a: assert property (@(posedge clk) disable iff (srst)
        $rose(state_ff == S_RD) && ir_op == `OP_TOPTR_H |-> wb_val_ff == dst_ff + `STEP_HALF)
        else $error("half-word pointer step not two");
    byte_step_a: assert property (@(posedge clk) disable iff (srst)
        $rose(state_ff == S_RD) && ir_op == `OP_FROMPTR_B |-> wb_val_ff == src_ff + `STEP_BYTE)
        else $error("byte pointer step not one");
    res_load_a: assert property (@(posedge clk) disable iff (srst)
        res_wr |-> ir_op == `OP_RES_LOAD ##1 (gr_we && gr_wdata == src_ff + `STEP_WORD))
        else $error("resource load wrong");
    res_store_a: assert property (@(posedge clk) disable iff (srst)
        res_rd |=> mem_we && mem_wdata == $past(res_rdata))
        else $error("resource store data lost");
    flags_hold_a: assert property (@(posedge clk) disable iff (srst)
        !instr_ready |-> !flags_we)
        else $error("condition flags written");

endmodule : direct_address_move_exec

/* tb/mem_res_model.sv */
`timescale 1ns/1ps

// ============================================================================
// Data memory and resource channels seen from the executor
module mem_res_model (
    input  wire logic        clk,        // Core clock.
    input  wire logic        srst,       // Synchronous reset, active high.
    input  wire logic [1:0]  wait_sel,   // Wait cycles before each memory answer.
    input  wire logic        mem_req,    // Access request.
    input  wire logic [31:0] mem_addr,   // Byte address.
    output logic             mem_ack,    // Access finished.
    output logic [31:0]      mem_rdata,  // Read data, full word.
    input  wire logic        res_wr,     // Word into a channel.
    input  wire logic        res_rd,     // Word out of a channel.
    input  wire logic [3:0]  res_chan,   // Channel number.
    input  wire logic [31:0] res_wdata,  // Word to the channel.
    output logic [31:0]      res_rdata   // Word from the channel.
);
    logic [1:0]  cnt_ff;
    logic [31:0] chan_ff [16];

    function automatic logic [31:0] pattern(input logic [31:0] a);
        return {a[15:0] ^ 16'h5a3c, ~a[15:0]};
    endfunction : pattern

    assign mem_ack   = mem_req && (cnt_ff == wait_sel);
    // Outside an answer the buses carry the inverse, so stale data never matches.
    assign mem_rdata = mem_ack ? pattern(mem_addr) : ~pattern(mem_addr);
    assign res_rdata = res_rd ? chan_ff[res_chan] : ~chan_ff[res_chan];

    always_ff @(posedge clk) begin
        cnt_ff <= (srst || mem_ack || !mem_req) ? 2'h0 : cnt_ff + 2'h1;
        for (int i = 0; i < 16; i++) begin
            if (srst) begin
                chan_ff[i] <= 32'hc0de_0000 | 32'(i);
            end
        end
        if (!srst && res_wr) begin
            chan_ff[res_chan] <= res_wdata;
        end
    end
endmodule : mem_res_model

/* tb/direct_address_move_exec_tb_top.sv */
`timescale 1ns/1ps

module direct_address_move_exec_tb_top;
    import direct_move_pkg::*;

    logic        clk, srst, instr_valid, instr_ready, mem_req, mem_we, mem_ack;
    logic        res_wr, res_rd, gr_we, flags_we, coproc_reject, done;
    logic [15:0] instr;
    logic [31:0] r13_in, r15_in, ri_in, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] res_wdata, res_rdata, gr_wdata;
    logic [31:0] chan_sh [16];
    logic [1:0]  mem_size, wait_sel;
    logic [3:0]  res_chan, gr_idx;
    logic [71:0] exp_q [$];
    int          mismatches, n_tests, n_done, exp_done;
    logic [11:0] ops [23] = '{12'h080, 12'h090, 12'h0a0, 12'h0b0, 12'h0c0, 12'h0d0,
                              12'h0e0, 12'h180, 12'h190, 12'h1a0, 12'h1b0, 12'h1c0,
                              12'h1d0, 12'h1e0, 12'hbc0, 12'hbd0, 12'h0f0, 12'h1f0,
                              12'h9fb, 12'h9fc, 12'h9fd, 12'h9fe, 12'h9ff};

    direct_address_move_exec u_direct_address_move_exec (.clk, .srst, .instr_valid,
        .instr_ready, .instr, .r13_in, .r15_in, .ri_in, .mem_req, .mem_we, .mem_addr,
        .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .res_wr, .res_rd, .res_chan,
        .res_wdata, .res_rdata, .gr_we, .gr_idx, .gr_wdata, .flags_we, .coproc_reject,
        .done);
    mem_res_model u_mem_res_model (.clk, .srst, .wait_sel, .mem_req, .mem_addr,
        .mem_ack, .mem_rdata, .res_wr, .res_rd, .res_chan, .res_wdata, .res_rdata);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    function automatic void fail(input string msg);
        mismatches++;
        $display("wrong value at %0t: %s", $time, msg);
    endfunction : fail

    function automatic void put(input logic [3:0] k, x, input logic [31:0] a, d);
        exp_q.push_back({k, x, a, d});
    endfunction : put

    function automatic logic [31:0] pat(input logic [31:0] a);
        return u_mem_res_model.pattern(a);
    endfunction : pat

    // Predicts the visible results of one instruction, then offers it until taken.
    task automatic issue(input logic [15:0] ins);
        logic [7:0]  op;
        logic [3:0]  ch, ix, sz;
        logic [31:0] da, st, m, r13, r15, ri;
        int          sh;
        op  = ins[15:8];
        ch  = ins[7:4];
        ix  = ins[3:0];
        r13 = $urandom;
        r15 = $urandom;
        ri  = (ix == 4'hd) ? r13 : (ix == 4'hf) ? r15 : $urandom;
        sh  = (op[1:0] == 2'h1) ? 1 : (op[1:0] == 2'h2) ? 0 : 2;
        sz  = (sh == 2) ? 4'(SZ_WORD) : (sh == 1) ? 4'(SZ_HALF) : 4'(SZ_BYTE);
        st  = 32'h1 << sh;
        m   = (sh == 2) ? 32'hffff_ffff : (sh == 1) ? 32'h0000_ffff : 32'h0000_00ff;
        da  = {24'h0, ins[7:0]} << sh;
        if (op inside {[8'h08:8'h0e], [8'h18:8'h1e], 8'hbc, 8'hbd}) exp_done++;
        case (op)
            8'h08, 8'h09, 8'h0a: put(4'h2, 4'hd, 0, pat(da) & m);
            8'h18, 8'h19, 8'h1a: put(4'h1, sz, da, r13 & m);
            8'h0c, 8'h0d, 8'h0e: begin
                put(4'h1, sz, r13, pat(da) & m);
                put(4'h2, 4'hd, 0, r13 + st);
            end
            8'h1c, 8'h1d, 8'h1e: begin
                put(4'h1, sz, da, pat(r13) & m);
                put(4'h2, 4'hd, 0, r13 + st);
            end
            8'h0b: begin
                put(4'h1, sz, r15 - 32'h4, pat(da));
                put(4'h2, 4'hf, 0, r15 - 32'h4);
            end
            8'h1b: begin
                put(4'h1, sz, da, pat(r15));
                put(4'h2, 4'hf, 0, r15 + 32'h4);
            end
            8'hbc: begin
                put(4'h3, ch, 0, pat(ri));
                chan_sh[ch] = pat(ri);
                put(4'h2, ix, 0, ri + 32'h4);
            end
            8'hbd: begin
                put(4'h1, 4'(SZ_WORD), ri, chan_sh[ch]);
                put(4'h2, ix, 0, ri + 32'h4);
            end
            8'h9f: if (ch[3:2] == 2'h3) put(4'h4, 0, 0, 0);
            default: ;
        endcase
        instr       <= ins;
        r13_in      <= r13;
        r15_in      <= r15;
        ri_in       <= ri;
        wait_sel    <= 2'($urandom_range(3, 0));
        instr_valid <= 1'b1;
        @(negedge clk);
        for (int n = 0; n < 64 && instr_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
    endtask : issue

    task automatic check(input logic [71:0] got);
        n_tests++;
        if (exp_q.size() == 0) fail($sformatf("unexpected result %h", got));
        else if (exp_q[0] !== got) fail($sformatf("got %h want %h", got, exp_q[0]));
        if (exp_q.size() != 0) void'(exp_q.pop_front());
    endtask : check

    always @(posedge clk) begin
        if (!srst) begin
            if (mem_req && mem_we && mem_ack)
                check({4'h1, 2'h0, mem_size, mem_addr, mem_wdata});
            if (res_wr) check({4'h3, res_chan, 32'h0, res_wdata});
            if (gr_we) check({4'h2, gr_idx, 32'h0, gr_wdata});
            if (coproc_reject) check({4'h4, 68'h0});
            if (flags_we !== 1'b0) fail("condition flags written");
            if (done === 1'b1) n_done++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail("timeout");
        stop_test();
    end

    initial begin
        logic [7:0] lo;
        {srst, instr_valid, instr, r13_in, r15_in, ri_in, wait_sel} = {2'b10, 114'h0};
        for (int i = 0; i < 16; i++) chan_sh[i] = 32'hc0de_0000 | 32'(i);
        void'($urandom(29));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (int r = 0; r < 6; r++) begin
            foreach (ops[i]) begin
                lo = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : 8'($urandom);
                issue({ops[i][11:4], (ops[i][11:4] == 8'h9f) ? {ops[i][3:0], lo[3:0]} : lo});
                if (ops[i][11:4] inside {8'h1c, 8'h1d, 8'h1e}) issue(16'h9fa0);
            end
        end
        instr_valid <= 1'b0;
        repeat (30) @(posedge clk);
        n_tests++;
        if (exp_q.size() != 0) fail("results missing");
        n_tests++;
        if (n_done != exp_done) fail("done count differs");
        stop_test();
    end
endmodule : direct_address_move_exec_tb_top
